/* core/clock_control_regs.vh */
// constants for the idle and economy clock control block
`ifndef CLOCK_CONTROL_REGS_VH
`define CLOCK_CONTROL_REGS_VH

// ------------------------------------------------------------
// power control register fields
// ------------------------------------------------------------
`define IDLE_BIT_POS        0
`define POWER_CONTROL_RESET 8'h00

// ------------------------------------------------------------
// power mode register fields
// ------------------------------------------------------------
`define DIV_FIELD_HI        7
`define DIV_FIELD_LO        6
`define POWER_MODE_RESET    8'h40
`define DIV_CODE_RESERVED   2'h0
`define DIV_CODE_4          2'h1
`define DIV_CODE_64         2'h2
`define DIV_CODE_1024       2'h3

// ------------------------------------------------------------
// timing counts, in system clocks
// ------------------------------------------------------------
`define CLOCKS_PER_CYCLE_4     11'h004
`define CLOCKS_PER_CYCLE_64    11'h040
`define CLOCKS_PER_CYCLE_1024  11'h400
`define RESET_MIN_CLOCKS       4'h8
`define WATCHDOG_RESET_DELAY   10'h200

`endif

/* core/cycle_divider.v */
// divider producing one-clock machine cycle ticks at a selected rate
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_regs.vh"

module cycle_divider (
  input  wire        clk,
  input  wire        rstSync_n,
  input  wire [10:0] period,
  output reg         tick
);

  reg [10:0] count_reg;

  // ------------------------------------------------------------
  // counter; a period change takes effect at once, so a drop in period can cut the current cycle short
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_reg <= 11'h000;
      tick      <= 1'b0;
    end else if (count_reg >= period - 11'h001) begin
      count_reg <= 11'h000;
      tick      <= 1'b1;
    end else begin
      count_reg <= count_reg + 11'h001;
      tick      <= 1'b0;
    end
  end

endmodule // cycle_divider

`default_nettype wire

/* core/watchdog_reset_timer.v */
// delay from watchdog time-out to watchdog reset, cancelled by a restart
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_regs.vh"

module watchdog_reset_timer (
  input  wire clk,
  input  wire rstSync_n,
  input  wire timeout,
  input  wire restart,
  output reg  wdReset
);

  reg        armed_reg;
  reg  [9:0] delay_reg;

  // ------------------------------------------------------------
  // count 512 clocks from the time-out unless software restarts the watchdog
  // ------------------------------------------------------------
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      armed_reg <= 1'b0;
      delay_reg <= 10'h000;
      wdReset   <= 1'b0;
    end else if (restart) begin
      armed_reg <= 1'b0;
      delay_reg <= 10'h000;
      wdReset   <= 1'b0;
    end else if (timeout && !armed_reg) begin
      armed_reg <= 1'b1;
      delay_reg <= 10'h001;
      wdReset   <= 1'b0;
    end else if (armed_reg) begin
      if (delay_reg == `WATCHDOG_RESET_DELAY - 10'h001) begin
        armed_reg <= 1'b0;
        wdReset   <= 1'b1;
      end else begin
        delay_reg <= delay_reg + 10'h001;
        wdReset   <= 1'b0;
      end
    end else begin
      wdReset <= 1'b0;
    end
  end

endmodule // watchdog_reset_timer

`default_nettype wire

/* core/idle_and_economy_clock_control.v */
// idle and economy mode clock control for a fast 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_regs.vh"

module idle_and_economy_clock_control (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        resetPin,
  input  wire        powerOnReset,
  input  wire        powerControlWrite,
  input  wire [7:0]  powerControlWdata,
  input  wire        powerModeWrite,
  input  wire [7:0]  powerModeWdata,
  input  wire        instrEnd,
  input  wire        interruptPending,
  input  wire        watchdogTimeout,
  input  wire        watchdogIntEnable,
  input  wire        watchdogRestart,
  input  wire        watchdogResetEnable,
  input  wire        coreAddrLatch,
  input  wire        coreProgramStoreStrobe,
  input  wire [31:0] corePortOut,
  output reg  [7:0]  power_control_reg,
  output reg  [7:0]  power_mode_reg,
  output reg         coreClockEnable,
  output reg         periphClockEnable,
  output reg         machineCycleTick,
  output reg         idleActive,
  output reg         coreReset,
  output reg  [15:0] resetVector,
  output reg         suppressNextInstr,
  output reg         wakeInterrupt,
  output reg         addrLatchOut,
  output reg         program_store_strobe,
  output reg  [31:0] portOut
);

  // ------------------------------------------------------------
  // reset release synchroniser
  // ------------------------------------------------------------
  reg        rstMeta_reg;
  reg        rstSync_reg;
  wire       rstSync_n = rstSync_reg;

  // the copy is also the reset of the divider and watchdog timer, so all
  // of the block leaves reset on one edge
  // release goes through two flops so no flop leaves reset on a metastable edge
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  // ------------------------------------------------------------
  // reset sources
  // ------------------------------------------------------------
  localparam ST_RUN   = 3'b001;
  localparam ST_ARM   = 3'b010;
  localparam ST_IDLE  = 3'b100;

  reg  [3:0]  pinCount_reg;
  reg  [3:0]  pinCount_next;
  reg         pinValid_reg;
  wire        wdReset;
  wire        anyReset = pinValid_reg | powerOnReset | wdReset;

  // the pin is level sensitive and counted in system clocks, so a glitch
  // or a short pulse from a bouncing supply never reaches the core
  // trade-off: a valid pin reset is seen nine clocks after it rises
  // power-on and watchdog resets act on the very next edge
  // a high on the pin counts only once held for the minimum clocks
  always @* begin
    pinCount_next = pinCount_reg;
    if (!resetPin)
      pinCount_next = 4'h0;
    else if (pinCount_reg != `RESET_MIN_CLOCKS)
      pinCount_next = pinCount_reg + 4'h1;
  end

  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinCount_reg <= 4'h0;
      pinValid_reg <= 1'b0;
    end else begin
      pinCount_reg <= pinCount_next;
      pinValid_reg <= (pinCount_next == `RESET_MIN_CLOCKS);
    end
  end

  watchdog_reset_timer u_watchdog (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .timeout   (watchdogTimeout & watchdogResetEnable),
    .restart   (watchdogRestart),
    .wdReset   (wdReset)
  );

  // ------------------------------------------------------------
  // divider selection
  // ------------------------------------------------------------
  reg  [1:0]  divActive_reg;
  reg  [1:0]  divPending_reg;
  reg         divPendingValid_reg;
  wire [10:0] cyclePeriod;
  wire        tick;

  // economy rate handling
  // the stored code and the code in force are kept apart, so software
  // reads back its write at once while the divider waits for an
  // instruction boundary
  // limitation: hardware does not police the /64 to /1024 rule; software
  // has to pass through /4 itself, a direct jump simply takes effect
  // decode of the two-bit divider code into clocks per machine cycle
  function [10:0] clocksFor;
    input [1:0] code;
    begin
      case (code)
        `DIV_CODE_64:   clocksFor = `CLOCKS_PER_CYCLE_64;
        `DIV_CODE_1024: clocksFor = `CLOCKS_PER_CYCLE_1024;
        default:        clocksFor = `CLOCKS_PER_CYCLE_4;
      endcase
    end
  endfunction

  // idle peripherals tick at /4 regardless of the selected economy rate
  assign cyclePeriod = idleActive ? `CLOCKS_PER_CYCLE_4 : clocksFor(divActive_reg);

  cycle_divider u_divider (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .period    (cyclePeriod),
    .tick      (tick)
  );

  // the register updates at once; the divider follows after one instruction end
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      power_mode_reg      <= `POWER_MODE_RESET;
      divActive_reg       <= `DIV_CODE_4;
      divPending_reg      <= `DIV_CODE_4;
      divPendingValid_reg <= 1'b0;
    end else if (anyReset) begin
      power_mode_reg      <= `POWER_MODE_RESET;
      divActive_reg       <= `DIV_CODE_4;
      divPendingValid_reg <= 1'b0;
    end else begin
      if (powerModeWrite) begin
        if (powerModeWdata[`DIV_FIELD_HI:`DIV_FIELD_LO] == `DIV_CODE_RESERVED)
          power_mode_reg <= {power_mode_reg[7:6], powerModeWdata[5:0]};
        else begin
          power_mode_reg      <= powerModeWdata;
          divPending_reg      <= powerModeWdata[`DIV_FIELD_HI:`DIV_FIELD_LO];
          divPendingValid_reg <= 1'b1;
        end
      end else if (divPendingValid_reg && instrEnd) begin
        divActive_reg       <= divPending_reg;
        divPendingValid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // idle state machine
  // ------------------------------------------------------------
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  wire        idleWrite = powerControlWrite && powerControlWdata[`IDLE_BIT_POS];
  wire        wake = interruptPending | (watchdogTimeout & watchdogIntEnable);

  // run: core clocked normally
  // arm: idle bit written, waiting for that instruction to finish
  // idle: core enable held low until a wake or a reset
  // any reset overrides every state so idle can never outlive a reset
  // idle takes hold only when the instruction doing the write completes
  always @* begin
    case (state_reg)
      ST_RUN:  state_next = idleWrite ? ST_ARM : ST_RUN;
      ST_ARM:  state_next = instrEnd ? ST_IDLE : ST_ARM;
      ST_IDLE: state_next = wake ? ST_RUN : ST_IDLE;
      default: state_next = ST_RUN;
    endcase
    if (anyReset)
      state_next = ST_RUN;
  end

  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // one decode of the idle state, shared by the enables, the pins and the status
  function isIdleState;
    input [2:0] st;
    begin
      isIdleState = (st == ST_IDLE);
    end
  endfunction

  wire        nextIdle = isIdleState(state_next);

  // ------------------------------------------------------------
  // power control register and wake flags
  // ------------------------------------------------------------
  // the wake flag is one clock long; the core uses it to vector into the
  // service routine and then resumes after the idle write
  // the suppress flag marks a reset that came in the arm or idle state, so the core drops
  // the instruction after the idle write and no stray store occurs
  // a write wins over the wake clear; wake clears only in idle
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      power_control_reg <= `POWER_CONTROL_RESET;
      wakeInterrupt     <= 1'b0;
      suppressNextInstr <= 1'b0;
    end else begin
      wakeInterrupt <= isIdleState(state_reg) && wake && !anyReset;
      if (anyReset) begin
        power_control_reg <= `POWER_CONTROL_RESET;
        suppressNextInstr <= (state_reg != ST_RUN);
      end else begin
        suppressNextInstr <= 1'b0;
        if (powerControlWrite)
          power_control_reg <= powerControlWdata;
        else if (isIdleState(state_reg) && wake)
          power_control_reg[`IDLE_BIT_POS] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // clock enables, reset outputs and pins
  // ------------------------------------------------------------
  // all outputs leave from flops, so every enable lags its tick by one
  // clock; the core and peripherals see the same lag and stay aligned
  // enables are registered; the core holds all state while its enable is low
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      idleActive        <= 1'b0;
      coreClockEnable   <= 1'b0;
      periphClockEnable <= 1'b0;
      machineCycleTick  <= 1'b0;
      coreReset         <= 1'b1;
      resetVector       <= 16'h0000;
    end else begin
      idleActive        <= nextIdle;
      coreClockEnable   <= tick && !nextIdle;
      periphClockEnable <= tick;
      machineCycleTick  <= tick;
      coreReset         <= anyReset;
      resetVector       <= 16'h0000;
    end
  end

  // the frozen port value is the one registered before the entry edge
  // hazard: a core port change on that very edge is not captured
  // strobes forced high and ports frozen for the whole idle period
  always @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      addrLatchOut         <= 1'b1;
      program_store_strobe <= 1'b1;
      portOut              <= 32'hFFFF_FFFF;
    end else if (nextIdle) begin
      addrLatchOut         <= 1'b1;
      program_store_strobe <= 1'b1;
      portOut              <= portOut;
    end else begin
      addrLatchOut         <= coreAddrLatch;
      program_store_strobe <= coreProgramStoreStrobe;
      portOut              <= corePortOut;
    end
  end

endmodule // idle_and_economy_clock_control

`default_nettype wire

/* tb/idle_and_economy_clock_control_asserts.sv */
// port assertions for the idle and economy clock control block
`timescale 1ns/1ps
`default_nettype none
module clock_control_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        resetPin,
  input wire logic        powerControlWrite,
  input wire logic        instrEnd,
  input wire logic [7:0]  power_control_reg,
  input wire logic [7:0]  power_mode_reg,
  input wire logic        coreClockEnable,
  input wire logic        periphClockEnable,
  input wire logic        machineCycleTick,
  input wire logic        idleActive,
  input wire logic        coreReset,
  input wire logic [15:0] resetVector,
  input wire logic        wakeInterrupt,
  input wire logic        addrLatchOut,
  input wire logic        program_store_strobe,
  input wire logic [31:0] portOut
);
  // ----------------------------------------------------------------
  // relations between the block's ports
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_IDLE_AFTER_INSTR: assert property ($rose(idleActive) |-> $past(instrEnd))
    else $error("idle began without an instruction end");
  AST_CORE_STOPPED: assert property (idleActive |-> !coreClockEnable)
    else $error("core clock enabled while idle");
  AST_STROBES_HIGH: assert property (idleActive |-> addrLatchOut && program_store_strobe)
    else $error("strobes not high while idle");
  AST_PORTS_FROZEN: assert property (idleActive && $past(idleActive) |-> $stable(portOut))
    else $error("port levels moved while idle");
  AST_WAKE_CLEARS: assert property (
    wakeInterrupt |-> $past(idleActive) && !idleActive && !power_control_reg[0])
    else $error("wake did not leave idle and clear the idle bit");
  // a pin that stays high eight clocks must be taken as a reset
  AST_PIN_RESET: assert property (resetPin [*8] |-> ##[0:3] coreReset)
    else $error("long reset pin level ignored");
  AST_VECTOR_ZERO: assert property (resetVector == 16'h0000)
    else $error("reset vector not zero");
  AST_IDLE_TICK_4: assert property (
    periphClockEnable && idleActive ##1 idleActive [*4] |-> periphClockEnable)
    else $error("peripheral tick not every four clocks in idle");
  AST_SAME_RATE: assert property (
    !idleActive && !$past(idleActive) && !coreReset && !$past(coreReset)
    |-> coreClockEnable == periphClockEnable && machineCycleTick == periphClockEnable)
    else $error("core and peripheral ticks differ");
  AST_DIV_NOT_RESERVED: assert property (power_mode_reg[7:6] != 2'h0)
    else $error("reserved divider code stored");
  AST_RESET_DEFAULTS: assert property (
    coreReset [*2] |-> power_mode_reg == 8'h40 && !idleActive)
    else $error("reset did not restore four clocks per cycle");
  AST_IDLE_BIT_HOLDS: assert property (
    $fell(power_control_reg[0]) |-> wakeInterrupt || coreReset || $past(coreReset)
    || $past(powerControlWrite))
    else $error("idle bit cleared without cause");
  // ----------------------------------------------------------------
  // main scenarios
  // ----------------------------------------------------------------
  COV_IDLE: cover property ($rose(idleActive));
  COV_WAKE: cover property (wakeInterrupt);
  COV_RESET_IDLE: cover property (idleActive ##1 coreReset);
  COV_SLOW: cover property (power_mode_reg[7:6] == 2'h3);
endmodule // clock_control_checker

bind idle_and_economy_clock_control clock_control_checker i_clock_control_checker (
  .clk, .reset_n, .resetPin, .powerControlWrite, .instrEnd, .power_control_reg,
  .power_mode_reg, .coreClockEnable, .periphClockEnable, .machineCycleTick, .idleActive,
  .coreReset, .resetVector, .wakeInterrupt, .addrLatchOut, .program_store_strobe, .portOut
);
`default_nettype wire

/* tb/test_idle_and_economy_clock_control.sv */
// self-checking bench for the idle and economy clock control block
`timescale 1ns/1ps
`default_nettype none
module test_idle_and_economy_clock_control;
  logic        clk = '0, reset_n = '0, resetPin = '0, powerOnReset = '0;
  logic        powerControlWrite = '0, powerModeWrite = '0, instrEnd = '0;
  logic        interruptPending = '0, watchdogTimeout = '0, watchdogIntEnable = '0;
  logic        watchdogRestart = '0, watchdogResetEnable = '0;
  logic        coreAddrLatch = '0, coreProgramStoreStrobe = '0;
  logic [7:0]  powerControlWdata = '0, powerModeWdata = '0, power_control_reg, power_mode_reg;
  logic [31:0] corePortOut = '0, portOut;
  logic [15:0] resetVector;
  logic        coreClockEnable, periphClockEnable, machineCycleTick, idleActive, coreReset;
  logic        suppressNextInstr, wakeInterrupt, addrLatchOut, program_store_strobe;
  int          mismatches = 0, checks_done = 0, cycles = 0, rstSeen = 0, supSeen = 0;
  int          ccSeen = 0, g, n, r;

  always #12.5 clk = ~clk;

  idle_and_economy_clock_control i_idle_and_economy_clock_control (
    .clk, .reset_n, .resetPin, .powerOnReset, .powerControlWrite, .powerControlWdata,
    .powerModeWrite, .powerModeWdata, .instrEnd, .interruptPending, .watchdogTimeout,
    .watchdogIntEnable, .watchdogRestart, .watchdogResetEnable, .coreAddrLatch,
    .coreProgramStoreStrobe, .corePortOut, .power_control_reg, .power_mode_reg,
    .coreClockEnable, .periphClockEnable, .machineCycleTick, .idleActive, .coreReset,
    .resetVector, .suppressNextInstr, .wakeInterrupt, .addrLatchOut, .program_store_strobe,
    .portOut
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // one write pulse to either register, readback settled on return
  task automatic wr(input bit pm, input logic [7:0] d);
    @(posedge clk) begin
      powerModeWrite <= pm;
      powerControlWrite <= !pm;
      powerModeWdata <= d;
      powerControlWdata <= d;
    end
    @(posedge clk) {powerModeWrite, powerControlWrite} <= 2'h0;
    cyc(1);
  endtask
  task automatic instr();
    @(posedge clk) instrEnd <= 1'b1;
    @(posedge clk) instrEnd <= 1'b0;
    #1;
  endtask
  // clocks between two peripheral ticks; waits are bounded
  task automatic gap(output int k);
    int w;
    w = 0;
    do begin cyc(1); w++; end while (periphClockEnable !== 1'b1 && w < 3000);
    k = 0;
    do begin cyc(1); k++; end while (periphClockEnable !== 1'b1 && k < 3000);
  endtask
  function automatic int cpc(input logic [1:0] c);
    return c == 2'h3 ? 1024 : c == 2'h2 ? 64 : 4;
  endfunction

  // cycle ceiling, event counts and random core strobes
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rstSeen <= rstSeen + (coreReset === 1'b1);
    supSeen <= supSeen + (suppressNextInstr === 1'b1);
    ccSeen <= ccSeen + (coreClockEnable === 1'b1);
    {coreAddrLatch, coreProgramStoreStrobe} <= 2'($urandom);
    if (cycles == 40000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    r = $urandom(32'h5b44);
    cyc(4);
    reset_n <= 1'b1;
    cyc(3);
    chk("mode reset", power_mode_reg, 8'h40);
    chk("control reset", power_control_reg, 8'h00);
    gap(g);
    chk("default rate", g, 4);
    // each slow rate waits for an instruction end, reserved code keeps it, then back to four
    for (int c = 2; c < 4; c++) begin
      wr(1, {c[1:0], 6'h15});
      chk("mode readback", power_mode_reg, {c[1:0], 6'h15});
      gap(g);
      chk("rate before instruction end", g, 4);
      instr();
      gap(g);
      gap(g);
      chk("economy rate", g, cpc(c[1:0]));
      wr(1, 8'h2a);
      instr();
      chk("reserved code", power_mode_reg, {c[1:0], 6'h2a});
      gap(g);
      gap(g);
      chk("rate after reserved", g, cpc(c[1:0]));
      wr(1, 8'h40);
      instr();
      gap(g);
      gap(g);
      chk("back to four", g, 4);
    end
    // idle under economy, woken by an interrupt and then by the watchdog
    wr(1, 8'h80);
    instr();
    for (int k = 0; k < 2; k++) begin
      r = $urandom;
      corePortOut <= r;
      wr(0, 8'h01);
      chk("idle bit set", power_control_reg[0], 1);
      chk("ports follow", portOut, r);
      cyc($urandom_range(6));
      instr();
      cyc(1);
      chk("idle entered", idleActive, 1);
      corePortOut <= ~r;
      n = ccSeen;
      gap(g);
      gap(g);
      chk("idle peripheral rate", g, 4);
      chk("core clock pulses", ccSeen - n, 0);
      chk("strobes", {addrLatchOut, program_store_strobe}, 2'h3);
      chk("ports frozen", portOut, r);
      interruptPending <= !k;
      watchdogIntEnable <= k;
      watchdogTimeout <= k;
      n = 0;
      while (wakeInterrupt !== 1'b1 && n < 50) begin cyc(1); n++; end
      chk("woken", wakeInterrupt, 1);
      chk("idle bit cleared", power_control_reg[0], 0);
      {interruptPending, watchdogIntEnable, watchdogTimeout} <= 3'h0;
      gap(g);
      gap(g);
      chk("peripheral rate after wake", g, 64);
    end
    // reset out of idle by the pin, then by power-on
    for (int k = 0; k < 2; k++) begin
      wr(0, 8'h01);
      instr();
      cyc(2);
      n = rstSeen;
      if (k == 0) begin
        resetPin <= 1'b1;
        cyc(6);
        resetPin <= 1'b0;
        cyc(6);
        chk("short pin pulse", rstSeen - n, 0);
      end
      r = supSeen;
      resetPin <= !k;
      powerOnReset <= k;
      cyc(12);
      {resetPin, powerOnReset} <= 2'h0;
      n = 0;
      while (coreReset !== 1'b0 && n < 50) begin cyc(1); n++; end
      chk("idle left", idleActive, 0);
      chk("mode after reset", power_mode_reg, 8'h40);
      chk("control after reset", power_control_reg, 8'h00);
      chk("next instruction dropped", supSeen > r, 1);
      gap(g);
      chk("rate after reset", g, 4);
      wr(1, 8'h80);
      instr();
    end
    // watchdog time-out: restart cancels the reset, otherwise reset follows
    watchdogResetEnable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) watchdogTimeout <= 1'b1;
      @(posedge clk) watchdogTimeout <= 1'b0;
      #1;
      n = rstSeen;
      g = 0;
      if (k == 0) begin
        cyc(300);
        watchdogRestart <= 1'b1;
        cyc(1);
        watchdogRestart <= 1'b0;
        cyc(400);
        chk("restart cancels", rstSeen - n, 0);
      end else begin
        while (coreReset !== 1'b1 && g < 600) begin cyc(1); g++; end
        chk("watchdog reset delay", g >= 512 && g <= 514, 1);
      end
    end
    watchdogResetEnable <= 1'b0;
    cyc(20);
    give_verdict();
  end
endmodule // test_idle_and_economy_clock_control
`default_nettype wire
